// file: verilog/rfbw_pkg.sv
// package for the remote fast buffered write arbiter
package rfbw_pkg;
  localparam logic [1:0] RFBW_MS_DATA_MEMORY = 2'h0;
  localparam logic [1:0] RFBW_MS_PMEM = 2'h1;
  localparam logic [1:0] RFBW_MS_PCLO = 2'h2;
  localparam logic [1:0] RFBW_MS_PCHI = 2'h3;
  localparam int RFBW_IW_POS = 3;
  localparam int RFBW_DW_POS = 0;
  localparam int RFBW_MS_POS = 0;
  localparam logic [7:0] RFBW_CTRL_RST = 8'h00;
  localparam logic [15:0] RFBW_PC_RST = 16'h0000;
  localparam logic [7:0] RFBW_CFG_RST = 8'h00;
  localparam logic [31:0] RFBW_ADDR_CFG = 32'h00000000;
  localparam logic [31:0] RFBW_ADDR_STAT = 32'h00000004;
  localparam logic [31:0] RFBW_ADDR_PC = 32'h00000008;
  localparam logic [31:0] RFBW_ADDR_CTRL = 32'h0000000C;
  typedef enum logic [3:0] {
    RFBW_IDLE = 4'h0,
    RFBW_HOLD = 4'h1,
    RFBW_TAKE = 4'h2,
    RFBW_ACC = 4'h3,
    RFBW_CTRL = 4'h4,
    RFBW_PCLO = 4'h5,
    RFBW_PCHI = 4'h6,
    RFBW_DATA_MEMORY = 4'h7,
    RFBW_ILO = 4'h8,
    RFBW_IHI = 4'h9,
    RFBW_TERM = 4'hA,
    RFBW_REL = 4'hB,
    RFBW_FIN = 4'hC
  } rfbw_state_t;
endpackage

// file: verilog/rfbw_top.sv
// remote fast buffered write arbiter with ahb-lite config slave
//
// The implementer's own choices: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
module rfbw_top
  import rfbw_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic remote_access_enable,
  input wire logic host_write_req_n,
  input wire logic ctrl_select,
  input wire logic wait_n,
  input wire logic cpu_bus_request,
  input wire logic cpu_data_memory_access,
  input wire logic [7:0] ad_in,
  output logic cpu_bus_grant,
  output logic cpu_host_wait,
  output logic transfer_ack_out,
  output logic local_bus_owner_n,
  output logic bus_oe,
  output logic data_memory_write_n,
  output logic progmem_write_n,
  output logic [15:0] progmem_wdata,
  output logic [7:0] remote_iface_ctrl,
  output logic [1:0] active_memory_select,
  output logic [15:0] program_counter,
  output logic upper_byte_flag
);
  rfbw_state_t state_r, state_nxt;
  logic en_s1_r, en_s2_r, wr_s1_r, wr_s2_r, wt_s1_r, wt_s2_r, cs_s1_r, cs_s2_r;
  logic [7:0] device_config_reg;
  logic [7:0] instr_low_hold;
  logic [2:0] wcnt_r;
  logic [1:0] ms_act_r;
  logic pmem_hi_r;
  logic ap_valid_r, ap_write_r;
  logic [31:0] ap_addr_r;

  // request synchronised before any decision
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      wr_s1_r <= 1'b1;
      wr_s2_r <= 1'b1;
      wt_s1_r <= 1'b1;
      wt_s2_r <= 1'b1;
      cs_s1_r <= 1'b0;
      cs_s2_r <= 1'b0;
    end
    else
    begin
      en_s1_r <= remote_access_enable;
      en_s2_r <= en_s1_r;
      wr_s1_r <= host_write_req_n;
      wr_s2_r <= wr_s1_r;
      wt_s1_r <= wait_n;
      wt_s2_r <= wt_s1_r;
      cs_s1_r <= ctrl_select;
      cs_s2_r <= cs_s1_r;
    end
  end

  wire remote_wr = en_s2_r & ~wr_s2_r;
  wire local_prio = remote_iface_ctrl[7];
  wire [1:0] memory_select = remote_iface_ctrl[RFBW_MS_POS +: 2];
  wire arb_state = (state_r == RFBW_IDLE) || (state_r == RFBW_HOLD);
  wire grant_ok = cpu_bus_request &&
                  (arb_state || state_r == RFBW_REL || state_r == RFBW_FIN);
  wire blocking = local_prio || cpu_bus_grant;
  wire acc_state = (state_r == RFBW_CTRL) || (state_r == RFBW_PCLO) ||
                   (state_r == RFBW_PCHI) || (state_r == RFBW_DATA_MEMORY) ||
                   (state_r == RFBW_ILO) || (state_r == RFBW_IHI);
  wire waits_done = (wcnt_r == 3'h0) && wt_s2_r;
  wire [2:0] wait_load = (memory_select == RFBW_MS_PMEM) ?
                         {1'b0, device_config_reg[RFBW_IW_POS +: 2]} :
                         device_config_reg[RFBW_DW_POS +: 3];
  wire held = !arb_state && state_r != RFBW_REL && state_r != RFBW_FIN;

  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      RFBW_IDLE, RFBW_HOLD:
        if (!remote_wr)
          state_nxt = RFBW_IDLE;
        else if (blocking)
          state_nxt = RFBW_HOLD;
        else if (!cpu_bus_request)
          state_nxt = RFBW_TAKE;
      RFBW_TAKE: state_nxt = RFBW_ACC;
      RFBW_ACC:
        if (cs_s2_r)
          state_nxt = RFBW_CTRL;
        else
          unique case (memory_select)
            RFBW_MS_PCLO: state_nxt = RFBW_PCLO;
            RFBW_MS_PCHI: state_nxt = RFBW_PCHI;
            RFBW_MS_DATA_MEMORY: state_nxt = RFBW_DATA_MEMORY;
            RFBW_MS_PMEM: state_nxt = upper_byte_flag ? RFBW_IHI : RFBW_ILO;
          endcase
      RFBW_CTRL, RFBW_PCLO, RFBW_PCHI, RFBW_DATA_MEMORY, RFBW_ILO, RFBW_IHI:
        if (waits_done)
          state_nxt = RFBW_TERM;
      RFBW_TERM: state_nxt = RFBW_REL;
      RFBW_REL: state_nxt = remote_wr ? RFBW_FIN : RFBW_IDLE;
      RFBW_FIN:
        if (!remote_wr)
          state_nxt = RFBW_IDLE;
      default: state_nxt = RFBW_IDLE;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      state_r <= RFBW_IDLE;
    else
      state_r <= state_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      wcnt_r <= 3'h0;
    else if (state_r == RFBW_TAKE)
      wcnt_r <= wait_load;
    else if (acc_state && wcnt_r != 3'h0)
      wcnt_r <= wcnt_r - 3'h1;
  end

  // outputs registered; owner and write strobes from next state, grant and host wait from current state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cpu_bus_grant <= 1'b0;
      cpu_host_wait <= 1'b0;
      transfer_ack_out <= 1'b1;
      local_bus_owner_n <= 1'b0;
      data_memory_write_n <= 1'b1;
      progmem_write_n <= 1'b1;
    end
    else
    begin
      cpu_bus_grant <= grant_ok;
      cpu_host_wait <= cpu_data_memory_access && !cpu_bus_grant && held;
      transfer_ack_out <= !((arb_state && remote_wr) || state_r == RFBW_TAKE ||
                           state_r == RFBW_ACC ||
                           acc_state && state_nxt != RFBW_TERM);
      local_bus_owner_n <= (state_nxt == RFBW_ACC || state_nxt == RFBW_TERM ||
                           (state_nxt >= RFBW_CTRL && state_nxt <= RFBW_IHI));
      data_memory_write_n <= !(state_nxt == RFBW_DATA_MEMORY);
      progmem_write_n <= !((state_nxt == RFBW_ACC && upper_byte_flag &&
                           memory_select == RFBW_MS_PMEM && !cs_s2_r) ||
                           state_nxt == RFBW_IHI);
    end
  end

  // bus release lags state by half a period on the falling edge
  always_ff @(negedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      bus_oe <= 1'b1;
    else
      bus_oe <= !held;
  end

  // data path and counter effects
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      instr_low_hold <= 8'h00;
      progmem_wdata <= 16'h0000;
      program_counter <= RFBW_PC_RST;
      upper_byte_flag <= 1'b0;
      pmem_hi_r <= 1'b0;
      ms_act_r <= 2'h0;
      remote_iface_ctrl <= RFBW_CTRL_RST;
      active_memory_select <= 2'h0;
    end
    else
    begin
      if (state_r == RFBW_ACC)
        pmem_hi_r <= 1'b0;
      if (state_r == RFBW_ILO && state_nxt == RFBW_TERM)
        instr_low_hold <= ad_in;
      if (state_r == RFBW_ACC && state_nxt == RFBW_IHI)
        progmem_wdata <= {ad_in, instr_low_hold};
      if (state_r == RFBW_PCLO && state_nxt == RFBW_TERM)
        program_counter[7:0] <= ad_in;
      else if (state_r == RFBW_PCHI && state_nxt == RFBW_TERM)
        program_counter[15:8] <= ad_in;
      else if (state_r == RFBW_TERM && pmem_hi_r)
        program_counter <= program_counter + 16'h0001;
      if (state_r == RFBW_ILO || state_r == RFBW_IHI)
        if (state_nxt == RFBW_TERM)
        begin
          upper_byte_flag <= ~upper_byte_flag;
          pmem_hi_r <= (state_r == RFBW_IHI);
        end
      if (state_r == RFBW_CTRL && state_nxt == RFBW_TERM)
      begin
        remote_iface_ctrl <= ad_in;
        if (ad_in[RFBW_MS_POS +: 2] == RFBW_MS_PMEM)
          upper_byte_flag <= 1'b0;
      end
      if (state_r == RFBW_REL)
        active_memory_select <= memory_select;
      ms_act_r <= memory_select;
    end
  end

  // ahb-lite slave: config writable, status readable
  wire ap_take = hsel && hready && htrans[1];
  wire [31:0] rd_addr = {haddr[31:2], 2'h0};
  wire [31:0] stat_word = {21'h000000, upper_byte_flag, state_r, ms_act_r,
                           wcnt_r, transfer_ack_out};
  wire [31:0] rd_word = (rd_addr == RFBW_ADDR_CFG) ? {24'h000000, device_config_reg} :
                        (rd_addr == RFBW_ADDR_STAT) ? stat_word :
                        (rd_addr == RFBW_ADDR_PC) ? {16'h0000, program_counter} :
                        (rd_addr == RFBW_ADDR_CTRL) ? {24'h000000, remote_iface_ctrl} :
                        32'h00000000;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_valid_r <= 1'b0;
      ap_write_r <= 1'b0;
      ap_addr_r <= 32'h00000000;
    end
    else if (hready)
    begin
      ap_valid_r <= ap_take;
      ap_write_r <= hwrite;
      ap_addr_r <= {haddr[31:2], 2'h0};
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      device_config_reg <= RFBW_CFG_RST;
    else if (ap_valid_r && ap_write_r && ap_addr_r == RFBW_ADDR_CFG)
      device_config_reg <= hwdata[7:0];
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h00000000;
    else if (ap_take && !hwrite)
      hrdata <= rd_word;
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  ack_low_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RFBW_TAKE) |-> !transfer_ack_out) else $error("ack not low");
  take_seq_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RFBW_TAKE) |=> (state_r == RFBW_ACC)) else $error("no access");
  owner_acc_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RFBW_ACC) |-> local_bus_owner_n) else $error("owner low");
  no_grant_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RFBW_ACC) |-> !cpu_bus_grant) else $error("grant in access");
  term_rel_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RFBW_TERM) |=> (state_r == RFBW_REL)) else $error("no release");
  flag_tog_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RFBW_ILO && state_nxt == RFBW_TERM) |=> upper_byte_flag)
    else $error("flag not set");
  idle_stay_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (state_r == RFBW_IDLE && !remote_wr) |=> (state_r == RFBW_IDLE))
    else $error("left idle");
  hold_a: assert property (@(posedge hclk) disable iff (!hresetn)
    (arb_state && remote_wr && local_prio) |=> (state_r == RFBW_HOLD))
    else $error("no hold");
endmodule

// file: test/rfbw_host_model.sv
// remote host model that writes single bytes over the fast buffered write link
`timescale 1ns/10ps
module rfbw_host_model
(
  input wire logic hclk,
  input wire logic transfer_ack_out,
  output logic remote_access_enable,
  output logic host_write_req_n,
  output logic ctrl_select,
  output logic wait_n,
  output logic [7:0] ad_in
);
  initial
  begin
    remote_access_enable = 1'b0;
    host_write_req_n = 1'b1;
    ctrl_select = 1'b0;
    wait_n = 1'b1;
    ad_in = 8'h00;
  end
  // low returns the cycles the acknowledge stayed low, -1 when it never came back
  task automatic write_byte(input logic sel, input logic [7:0] d, input int extra,
                            output int low);
    int n;
    low = 0;
    remote_access_enable <= 1'b1;
    host_write_req_n <= 1'b0;
    ctrl_select <= sel;
    ad_in <= d;
    wait_n <= (extra == 0);
    for (n = 0; n < 300; n++)
    begin
      @(posedge hclk);
      if (n == extra) wait_n <= 1'b1;
      if (transfer_ack_out === 1'b0) low++;
      else if (low > 0) break;
    end
    if (n == 300) low = -1;
    // released lines show the inverse so a stale byte cannot pass
    remote_access_enable <= 1'b0;
    host_write_req_n <= 1'b1;
    ctrl_select <= ~sel;
    ad_in <= ~d;
  endtask
endmodule

// file: test/testbench.sv
// self-checking bench for the remote fast buffered write arbiter
`timescale 1ns/10ps
module testbench;
  import rfbw_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready, hreadyout, hresp;
  logic remote_access_enable, host_write_req_n, ctrl_select, wait_n;
  logic [7:0] ad_in;
  logic cpu_bus_request = 1'b0;
  logic cpu_data_memory_access = 1'b0;
  logic cpu_bus_grant, cpu_host_wait, transfer_ack_out, local_bus_owner_n, bus_oe;
  logic data_memory_write_n, progmem_write_n, upper_byte_flag;
  logic [15:0] progmem_wdata, program_counter;
  logic [7:0] remote_iface_ctrl;
  logic [1:0] active_memory_select;
  logic dfall, pfall;
  logic [31:0] rd;
  int bad_count = 0;
  int checked = 0;
  int low, base;
  assign hready = hreadyout;
  always #2 hclk = ~hclk;
  rfbw_top i_dut (.*);
  rfbw_host_model i_host (.*);
  // remember whether a write strobe fell since last cleared
  always @(posedge hclk)
  begin
    if (data_memory_write_n === 1'b0) dfall <= 1'b1;
    if (progmem_write_n === 1'b0) pfall <= 1'b1;
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
                     output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  endtask
  task automatic hw(input logic sel, input logic [7:0] d, input int extra);
    i_host.write_byte(sel, d, extra, low);
    check({31'h0, low > 0}, 32'h1);
    repeat (4) @(posedge hclk);
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d errors=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    check(transfer_ack_out, 32'h1);
    check(local_bus_owner_n, 32'h0);
    check(bus_oe, 32'h1);
    check(upper_byte_flag, 32'h0);
    check(program_counter, RFBW_PC_RST);
    check(remote_iface_ctrl, RFBW_CTRL_RST);
    ahb(1'b0, RFBW_ADDR_CFG, 32'h0, rd);
    check(rd, RFBW_CFG_RST);
    ahb(1'b1, 32'h10, 32'hFF, rd);
    ahb(1'b0, 32'h10, 32'h0, rd);
    check(rd, 32'h0);
    ahb(1'b1, RFBW_ADDR_CFG, 32'h0A, rd);
    ahb(1'b0, RFBW_ADDR_CFG, 32'h0, rd);
    check(rd, 32'h0A);
    hw(1'b1, 8'h01, 0);
    check(remote_iface_ctrl, 32'h01);
    check(active_memory_select, RFBW_MS_PMEM);
    hw(1'b0, 8'h55, 0);
    check(upper_byte_flag, 32'h1);
    hw(1'b1, 8'h01, 0);
    check(upper_byte_flag, 32'h0);
    pfall = 1'b0;
    hw(1'b0, 8'h34, 0);
    check(pfall, 32'h0);
    hw(1'b0, 8'h12, 0);
    check(pfall, 32'h1);
    check(progmem_wdata, 32'h1234);
    check(upper_byte_flag, 32'h0);
    check(program_counter, 32'h0001);
    hw(1'b1, 8'h02, 0);
    hw(1'b0, 8'h40, 0);
    hw(1'b1, 8'h03, 0);
    hw(1'b0, 8'h12, 0);
    ahb(1'b0, RFBW_ADDR_PC, 32'h0, rd);
    check(rd, 32'h1240);
    hw(1'b1, 8'h00, 0);
    dfall = 1'b0;
    i_host.write_byte(1'b0, 8'hA5, 0, base);
    check(dfall, 32'h1);
    check({31'h0, base >= 5}, 32'h1);
    repeat (4) @(posedge hclk);
    i_host.write_byte(1'b0, 8'h5A, 14, low);
    check({31'h0, low > base}, 32'h1);
    repeat (4) @(posedge hclk);
    cpu_bus_request <= 1'b1;
    repeat (3) @(posedge hclk);
    check(cpu_bus_grant, 32'h1);
    fork
      hw(1'b0, 8'h77, 20);
      begin
        repeat (8) @(posedge hclk);
        check(transfer_ack_out, 32'h0);
        check(cpu_bus_grant, 32'h1);
        cpu_bus_request <= 1'b0;
        repeat (6) @(posedge hclk);
        cpu_bus_request <= 1'b1;
        cpu_data_memory_access <= 1'b1;
        repeat (2) @(posedge hclk);
        check(cpu_bus_grant, 32'h0);
        check(cpu_host_wait, 32'h1);
        check(local_bus_owner_n, 32'h1);
        check(bus_oe, 32'h0);
      end
    join
    check(cpu_bus_grant, 32'h1);
    check(cpu_host_wait, 32'h0);
    check(local_bus_owner_n, 32'h0);
    check(bus_oe, 32'h1);
    tally_and_finish;
  end
  initial
  begin
    #40000;
    bad_count++;
    tally_and_finish;
  end
endmodule
